// *** design/backlight_regs.svh ***
`ifndef BACKLIGHT_REGS_SVH
`define BACKLIGHT_REGS_SVH

// register addresses
`define ADDR_PART_ID 8'h01
`define ADDR_CFG_PRI 8'h02
`define ADDR_CFG_SEC 8'h03
`define ADDR_BRT_LOW 8'h04
`define ADDR_BRT_HIGH 8'h05
`define ADDR_ENABLES 8'h08

// reset values
`define RST_CFG_PRI 8'hFA
`define RST_CFG_SEC 8'h8D
`define RST_BRT_LOW 3'h7
`define RST_BRT_HIGH 8'hFF
`define RST_ENABLES 7'h3F
`define RST_COMMIT_MAP 1'h1

// field positions
`define POS_OVP_HI 7
`define POS_OVP_LO 5
`define POS_OVP_RESP 4
`define POS_MAP_SEL 3
`define POS_PWM_POL 2
`define POS_RAMP_SHAPE 1
`define POS_PWM_EN 0
`define POS_MUST_ONE 7
`define POS_TRANS_HI 6
`define POS_TRANS_LO 3
`define POS_HYST_HI 2
`define POS_HYST_LO 0
`define POS_SW_RESET 7
`define POS_MASTER_EN 6

// timing: one brightness step per microsecond for transition code zero
`define STEP_TIME_NS 1000
`define STEP_CYCLES (`STEP_TIME_NS / 8)

`endif

// *** design/backlight_pkg.sv ***
package backlight_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [10:0] brightness_t;
    typedef enum logic {
        MAP_EXPONENTIAL,
        MAP_LINEAR
    } mapping_e;
endpackage : backlight_pkg

// *** design/backlight_control_register_bank.sv ***
// Overview of operation
// - over-voltage threshold code in bits 7:5, reset all ones, to boost protection
// - response bit 0 reports only; 1 (default) switches off offending string
// - mapping bit 3 selects exponential/linear; takes effect on next MSB write
// - bit 1 picks ramp shape: 0 exponential, 1 linear by default
// - bit 2 sets PWM input polarity: 0 active high, 1 active low
// - bit 0 enables PWM dimming; clear means PWM input ignored
// - bits 6:3 set fixed transition time, default 0001 for 2 ms
// - transition code 0000 steps brightness once per microsecond
// - bits 2:0 set PWM duty hysteresis, twice code in LSBs, default 10
// - 11-bit brightness from 3 low bits and 8 high bits, reset all ones
// - low-bit write held pending; high-bit write commits whole 11-bit code
// - committed code zero switches off boost converter and all sinks
// - writing 1 to enable bit 7 resets all registers; bit self-clears
// - enable bit 6 is master backlight enable, default off
// - enable bits 5:0 enable sinks six to one, default all on
// - register address advances by one after each acknowledged data byte
// - defaults restored on power-on, hardware-enable toggle, and software reset
`include "backlight_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module backlight_control_register_bank
    import backlight_pkg::*;
#(
    // identification field; the value is arbitrary
    parameter logic [2:0] PART_ID_CODE = 3'h5
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic HARDWARE_ENABLE_PIN,
    input wire logic ADDR_LOAD,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_STROBE,
    input wire logic [7:0] WR_DATA,
    input wire logic RD_ACK,
    output logic [7:0] RD_DATA,
    output logic [7:0] REG_ADDR,
    output logic [2:0] OVERVOLTAGE_THRESHOLD_CODE,
    output logic OVERVOLTAGE_RESPONSE_SELECT,
    output logic BRIGHTNESS_MAPPING_SELECT,
    output logic PWM_ACTIVE_LOW,
    output logic RAMP_SHAPE_LINEAR,
    output logic PWM_DIMMING_ENABLE,
    output logic [3:0] TRANSITION_TIME_CODE,
    output logic [4:0] DUTY_CHANGE_THRESHOLD,
    output logic [10:0] BRIGHTNESS_CODE,
    output logic BRIGHTNESS_COMMIT,
    output logic UNIT_STEP_TICK,
    output logic BOOST_AND_SINKS_OFF,
    output logic BACKLIGHT_MASTER_ENABLE,
    output logic [5:0] SINK_ENABLES
);

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic hardware_enable_pin_meta_q;
    logic hardware_enable_pin_sync_q;
    logic hardware_enable_pin_prev_q;
    logic hardware_enable_pin_toggle;
    logic soft_reset_q;
    logic [1:0] hardware_enable_pin_armed_q;
    logic defaults;

    // pin passes two flops before anything looks at it; the chain runs
    // through reset so it already holds the pin level when reset ends
    always_ff @(posedge SYS_CLK) begin
        hardware_enable_pin_meta_q <= HARDWARE_ENABLE_PIN;
        hardware_enable_pin_sync_q <= hardware_enable_pin_meta_q;
        hardware_enable_pin_prev_q <= hardware_enable_pin_sync_q;
    end

    // edge detector blind until the chain refills after reset, else a pin
    // resting high would look like a fresh toggle; a pin edge inside that window is missed
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            hardware_enable_pin_armed_q <= 2'h0;
        end else begin
            hardware_enable_pin_armed_q <= {hardware_enable_pin_armed_q[0], 1'h1};
        end
    end

    assign hardware_enable_pin_toggle = hardware_enable_pin_armed_q[1] && (hardware_enable_pin_sync_q ^ hardware_enable_pin_prev_q);
    // any pin change sampled once armed restores defaults, so low time need only cover one clock edge
    assign defaults = RESET || hardware_enable_pin_toggle || soft_reset_q;

    // ------------------------------------------------------------
    // address pointer
    // ------------------------------------------------------------
    logic [7:0] addr_q;

    // pointer steps after each acknowledged byte, either direction
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            addr_q <= 8'h00;
        end else if (ADDR_LOAD) begin
            addr_q <= ADDR_IN;
        end else if (WR_STROBE || RD_ACK) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    assign REG_ADDR = addr_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = WR_STROBE && (a == target);
    endfunction : hit

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [2:0] ovp_code_q;
    logic ovp_resp_q;
    logic map_sel_q;
    logic pwm_pol_q;
    logic ramp_shape_q;
    logic pwm_en_q;
    logic [3:0] trans_code_q;
    logic [2:0] hyst_code_q;
    logic [2:0] brt_low_q;
    logic [7:0] brt_high_q;
    logic master_en_q;
    logic [5:0] sink_en_q;
    logic wr_cfg_pri;
    logic wr_cfg_sec;
    logic wr_enables;

    // reset images, seven bits for enables; each config and enable field below takes its own slice
    localparam logic [7:0] cfg_pri_rst = `RST_CFG_PRI;
    localparam logic [7:0] cfg_sec_rst = `RST_CFG_SEC;
    localparam logic [6:0] enables_rst = `RST_ENABLES;

    // write decodes shared by the field processes
    assign wr_cfg_pri = hit(addr_q, `ADDR_CFG_PRI);
    assign wr_cfg_sec = hit(addr_q, `ADDR_CFG_SEC);
    assign wr_enables = hit(addr_q, `ADDR_ENABLES);

    // threshold code feeds the boost protection comparator
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            ovp_code_q <= cfg_pri_rst[`POS_OVP_HI:`POS_OVP_LO];
        end else if (wr_cfg_pri) begin
            ovp_code_q <= WR_DATA[`POS_OVP_HI:`POS_OVP_LO];
        end
    end

    // report only, or shut off the string that tripped
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            ovp_resp_q <= cfg_pri_rst[`POS_OVP_RESP];
        end else if (wr_cfg_pri) begin
            ovp_resp_q <= WR_DATA[`POS_OVP_RESP];
        end
    end

    // mapping as written; the string only sees it after a high-byte commit
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            map_sel_q <= cfg_pri_rst[`POS_MAP_SEL];
        end else if (wr_cfg_pri) begin
            map_sel_q <= WR_DATA[`POS_MAP_SEL];
        end
    end

    // polarity of the dimming input
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            pwm_pol_q <= cfg_pri_rst[`POS_PWM_POL];
        end else if (wr_cfg_pri) begin
            pwm_pol_q <= WR_DATA[`POS_PWM_POL];
        end
    end

    // ramp shape applies to every current change
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            ramp_shape_q <= cfg_pri_rst[`POS_RAMP_SHAPE];
        end else if (wr_cfg_pri) begin
            ramp_shape_q <= WR_DATA[`POS_RAMP_SHAPE];
        end
    end

    // with dimming off the pwm input is ignored downstream
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            pwm_en_q <= cfg_pri_rst[`POS_PWM_EN];
        end else if (wr_cfg_pri) begin
            pwm_en_q <= WR_DATA[`POS_PWM_EN];
        end
    end

    // must-be-one bit is not stored; it always reads 1
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            trans_code_q <= cfg_sec_rst[`POS_TRANS_HI:`POS_TRANS_LO];
        end else if (wr_cfg_sec) begin
            trans_code_q <= WR_DATA[`POS_TRANS_HI:`POS_TRANS_LO];
        end
    end

    // hysteresis code; the doubling happens at the output
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            hyst_code_q <= cfg_sec_rst[`POS_HYST_HI:`POS_HYST_LO];
        end else if (wr_cfg_sec) begin
            hyst_code_q <= WR_DATA[`POS_HYST_HI:`POS_HYST_LO];
        end
    end

    // low bits only staged; reserved high bits dropped
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            brt_low_q <= `RST_BRT_LOW;
        end else if (hit(addr_q, `ADDR_BRT_LOW)) begin
            brt_low_q <= WR_DATA[2:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            brt_high_q <= `RST_BRT_HIGH;
        end else if (hit(addr_q, `ADDR_BRT_HIGH)) begin
            brt_high_q <= WR_DATA;
        end
    end

    // master enable kept apart from the sinks so the zero-code gate stays simple
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            master_en_q <= enables_rst[`POS_MASTER_EN];
        end else if (wr_enables) begin
            master_en_q <= WR_DATA[`POS_MASTER_EN];
        end
    end

    // one enable per current sink, bit 0 for sink one
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            sink_en_q <= enables_rst[5:0];
        end else if (wr_enables) begin
            sink_en_q <= WR_DATA[5:0];
        end
    end

    // reset bit is a pulse that clears next cycle; it reads back zero because the read mux puts a constant 0 in bit 7
    always_ff @(posedge SYS_CLK) begin
        if (RESET || soft_reset_q) begin
            soft_reset_q <= 1'h0;
        end else begin
            soft_reset_q <= hit(addr_q, `ADDR_ENABLES) && WR_DATA[`POS_SW_RESET];
        end
    end

    // ------------------------------------------------------------
    // committed brightness and mapping
    // ------------------------------------------------------------
    logic [10:0] code_q;
    logic map_q;
    logic commit_q;

    // high write commits staged low bits and the current mapping together
    always_ff @(posedge SYS_CLK) begin
        if (defaults) begin
            code_q <= {`RST_BRT_HIGH, `RST_BRT_LOW};
            map_q <= `RST_COMMIT_MAP;
            commit_q <= 1'h0;
        end else begin
            commit_q <= hit(addr_q, `ADDR_BRT_HIGH);
            if (hit(addr_q, `ADDR_BRT_HIGH)) begin
                code_q <= {WR_DATA, brt_low_q};
                map_q <= map_sel_q;
            end
        end
    end

    // ------------------------------------------------------------
    // microsecond step tick for transition code zero
    // ------------------------------------------------------------
    logic [6:0] step_cnt_q;
    logic tick_q;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            step_cnt_q <= 7'h00;
            tick_q <= 1'h0;
        end else if (step_cnt_q == 7'((`STEP_CYCLES) - 1)) begin
            step_cnt_q <= 7'h00;
            tick_q <= 1'h1;
        end else begin
            step_cnt_q <= step_cnt_q + 7'h01;
            tick_q <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_q;

    // unmapped addresses read zero
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rd_q <= 8'h00;
        end else begin
            unique case (addr_q)
                `ADDR_PART_ID: rd_q <= {2'h0, PART_ID_CODE, 3'h0};
                `ADDR_CFG_PRI: rd_q <= {ovp_code_q, ovp_resp_q, map_sel_q, pwm_pol_q, ramp_shape_q, pwm_en_q};
                `ADDR_CFG_SEC: rd_q <= {1'h1, trans_code_q, hyst_code_q};
                `ADDR_BRT_LOW: rd_q <= {5'h00, brt_low_q};
                `ADDR_BRT_HIGH: rd_q <= brt_high_q;
                `ADDR_ENABLES: rd_q <= {1'h0, master_en_q, sink_en_q};
                default: rd_q <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs to the backlight logic
    // ------------------------------------------------------------
    logic zero_code;

    assign zero_code = (code_q == 11'h000);
    assign RD_DATA = rd_q;
    assign OVERVOLTAGE_THRESHOLD_CODE = ovp_code_q;
    assign OVERVOLTAGE_RESPONSE_SELECT = ovp_resp_q;
    assign BRIGHTNESS_MAPPING_SELECT = map_q;
    assign PWM_ACTIVE_LOW = pwm_pol_q;
    assign RAMP_SHAPE_LINEAR = ramp_shape_q;
    assign PWM_DIMMING_ENABLE = pwm_en_q;
    assign TRANSITION_TIME_CODE = trans_code_q;
    // hysteresis in LSBs is twice the code
    assign DUTY_CHANGE_THRESHOLD = {1'h0, hyst_code_q, 1'h0};
    assign BRIGHTNESS_CODE = code_q;
    assign BRIGHTNESS_COMMIT = commit_q;
    assign UNIT_STEP_TICK = tick_q;
    assign BOOST_AND_SINKS_OFF = zero_code;
    assign BACKLIGHT_MASTER_ENABLE = master_en_q && !zero_code;
    assign SINK_ENABLES = zero_code ? 6'h00 : sink_en_q;

endmodule : backlight_control_register_bank

`default_nettype wire

// *** dv/backlight_bank_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// port-level checks of the bank
// ----
module backlight_bank_checker (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic ADDR_LOAD,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_STROBE,
    input wire logic [7:0] WR_DATA,
    input wire logic RD_ACK,
    input wire logic [7:0] REG_ADDR,
    input wire logic [2:0] OVERVOLTAGE_THRESHOLD_CODE,
    input wire logic [3:0] TRANSITION_TIME_CODE,
    input wire logic [4:0] DUTY_CHANGE_THRESHOLD,
    input wire logic [10:0] BRIGHTNESS_CODE,
    input wire logic BRIGHTNESS_COMMIT,
    input wire logic UNIT_STEP_TICK,
    input wire logic BOOST_AND_SINKS_OFF,
    input wire logic BACKLIGHT_MASTER_ENABLE,
    input wire logic [5:0] SINK_ENABLES
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    // data byte taken; a reload wins over the increment
    wire wr_take = WR_STROBE && !ADDR_LOAD;
    a_ptr_load: assert property (ADDR_LOAD |=> REG_ADDR == $past(ADDR_IN))
        else $error("pointer did not load");
    a_ptr_wr_step: assert property (wr_take |=> REG_ADDR == $past(REG_ADDR) + 8'h01)
        else $error("pointer did not step on write");
    a_ptr_ack_step: assert property (RD_ACK && !ADDR_LOAD |=> REG_ADDR == $past(REG_ADDR) + 8'h01)
        else $error("pointer did not step on ack");
    a_msb_commits: assert property (wr_take && REG_ADDR == 8'h05 |=> BRIGHTNESS_COMMIT)
        else $error("high byte write not committed");
    a_commit_high_byte: assert property (BRIGHTNESS_COMMIT |-> BRIGHTNESS_CODE[10:3] == $past(WR_DATA))
        else $error("committed high byte wrong");
    a_code_held: assert property ($changed(BRIGHTNESS_CODE) |-> BRIGHTNESS_COMMIT || BRIGHTNESS_CODE == 11'h7FF)
        else $error("code moved without commit");
    a_zero_all_off: assert property (BRIGHTNESS_CODE == 11'h000 |-> BOOST_AND_SINKS_OFF && SINK_ENABLES == 6'h00 && !BACKLIGHT_MASTER_ENABLE)
        else $error("zero code left output on");
    a_ovp_written: assert property (wr_take && REG_ADDR == 8'h02 |=> OVERVOLTAGE_THRESHOLD_CODE == $past(WR_DATA[7:5]))
        else $error("threshold not written");
    a_sec_written: assert property (wr_take && REG_ADDR == 8'h03 |=>
        DUTY_CHANGE_THRESHOLD == {1'b0, $past(WR_DATA[2:0]), 1'b0} && TRANSITION_TIME_CODE == $past(WR_DATA[6:3]))
        else $error("secondary fields wrong");
    a_tick_period: assert property (UNIT_STEP_TICK |-> ##125 UNIT_STEP_TICK)
        else $error("tick period wrong");
    a_soft_reset: assert property (wr_take && REG_ADDR == 8'h08 && WR_DATA[7] |->
        ##[1:3] (SINK_ENABLES == 6'h3F && BRIGHTNESS_CODE == 11'h7FF))
        else $error("software reset missed");
endmodule : backlight_bank_checker
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// host side of the command port
// ----
module host_model (
    input wire logic SYS_CLK,
    input wire logic [7:0] RD_DATA,
    output logic ADDR_LOAD,
    output logic [7:0] ADDR_IN,
    output logic WR_STROBE,
    output logic [7:0] WR_DATA,
    output logic RD_ACK
);
    // idle port from time zero
    initial begin
        ADDR_LOAD = 1'b0;
        ADDR_IN = 8'h00;
        WR_STROBE = 1'b0;
        WR_DATA = 8'h00;
        RD_ACK = 1'b0;
    end
    // address byte then n data bytes, low byte first, no gaps
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        @(posedge SYS_CLK) #1;
        ADDR_LOAD = 1'b1;
        ADDR_IN = a;
        for (int i = 0; i < n; i++) begin
            @(posedge SYS_CLK) #1;
            ADDR_LOAD = 1'b0;
            ADDR_IN = ~a;
            WR_STROBE = 1'b1;
            WR_DATA = d[8*i +: 8];
        end
        @(posedge SYS_CLK) #1;
        WR_STROBE = 1'b0;
        WR_DATA = ~WR_DATA;  // released data must not look valid
    endtask : wr
    // read data is one cycle behind the pointer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge SYS_CLK) #1;
        ADDR_LOAD = 1'b1;
        ADDR_IN = a;
        @(posedge SYS_CLK) #1;
        ADDR_LOAD = 1'b0;
        ADDR_IN = ~a;
        @(posedge SYS_CLK) #1;
        d = RD_DATA;
    endtask : rd
    // acknowledge the byte just read and fetch the next one
    task automatic nxt(output logic [7:0] d);
        RD_ACK = 1'b1;
        @(posedge SYS_CLK) #1;
        RD_ACK = 1'b0;
        @(posedge SYS_CLK) #1;
        d = RD_DATA;
    endtask : nxt
endmodule : host_model
`default_nettype wire

// *** dv/backlight_control_register_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// register bank bench
// ----
module backlight_control_register_bank_tb;
    import backlight_pkg::*;
    localparam logic [2:0] ID_CODE = 3'h2;  // arbitrary value
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic HARDWARE_ENABLE_PIN = 1'b1;
    logic ADDR_LOAD, WR_STROBE, RD_ACK, BRIGHTNESS_MAPPING_SELECT, PWM_ACTIVE_LOW, RAMP_SHAPE_LINEAR;
    logic OVERVOLTAGE_RESPONSE_SELECT, PWM_DIMMING_ENABLE, BRIGHTNESS_COMMIT, UNIT_STEP_TICK;
    logic BOOST_AND_SINKS_OFF, BACKLIGHT_MASTER_ENABLE;
    logic [7:0] ADDR_IN, WR_DATA, RD_DATA, REG_ADDR;
    logic [2:0] OVERVOLTAGE_THRESHOLD_CODE;
    logic [3:0] TRANSITION_TIME_CODE;
    logic [4:0] DUTY_CHANGE_THRESHOLD;
    logic [10:0] BRIGHTNESS_CODE;
    logic [5:0] SINK_ENABLES;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    reg_byte_t rv;
    backlight_control_register_bank #(.PART_ID_CODE(ID_CODE)) u_backlight_control_register_bank (.*);
    host_model u_host_model (.*);
    always #4 SYS_CLK = ~SYS_CLK;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdchk(input reg_byte_t a, input reg_byte_t exp);
        u_host_model.rd(a, rv);
        chk("register", {3'b000, rv}, {3'b000, exp});
    endtask : rdchk
    // hang guard, well above the sequence length
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge SYS_CLK);
        #1;
        RESET = 1'b0;
        // defaults, then a write to the read-only place
        rdchk(8'h01, {2'b00, ID_CODE, 3'b000});
        rdchk(8'h02, 8'hFA);
        rdchk(8'h03, 8'h8D);
        rdchk(8'h04, 8'h07);
        rdchk(8'h05, 8'hFF);
        rdchk(8'h08, 8'h3F);
        u_host_model.wr(8'h01, 16'h00FF, 1);
        rdchk(8'h01, {2'b00, ID_CODE, 3'b000});
        // mapping change must wait for the next high-byte write
        u_host_model.wr(8'h02, 16'h0005, 1);
        chk("cfg", {3'b0, OVERVOLTAGE_THRESHOLD_CODE, OVERVOLTAGE_RESPONSE_SELECT, BRIGHTNESS_MAPPING_SELECT,
            PWM_ACTIVE_LOW, RAMP_SHAPE_LINEAR, PWM_DIMMING_ENABLE}, 11'h00D);
        u_host_model.wr(8'h03, 16'h0087, 1);
        chk("sec", {2'b0, TRANSITION_TIME_CODE, DUTY_CHANGE_THRESHOLD}, 11'h00E);
        u_host_model.wr(8'h04, 16'h00FA, 1);
        chk("code", BRIGHTNESS_CODE, 11'h7FF);
        rdchk(8'h04, 8'h02);
        u_host_model.wr(8'h05, 16'h0010, 1);
        chk("code", BRIGHTNESS_CODE, 11'h082);
        chk("map", {10'h0, BRIGHTNESS_MAPPING_SELECT}, 11'h000);
        u_host_model.wr(8'h08, 16'h007A, 1);
        chk("en", {3'b0, BOOST_AND_SINKS_OFF, BACKLIGHT_MASTER_ENABLE, SINK_ENABLES}, 11'h07A);
        // low then high in one burst, to a zero code
        u_host_model.wr(8'h04, 16'h0000, 2);
        chk("off", {3'b0, BOOST_AND_SINKS_OFF, BACKLIGHT_MASTER_ENABLE, SINK_ENABLES}, 11'h080);
        u_host_model.rd(8'h02, rv);
        u_host_model.nxt(rv);
        chk("burst", {3'b0, rv}, 11'h087);
        // software reset, then an eight-bit host
        u_host_model.wr(8'h08, 16'h0080, 1);
        repeat (2) @(posedge SYS_CLK);
        rdchk(8'h08, 8'h3F);
        rdchk(8'h02, 8'hFA);
        chk("cfg", {3'b0, OVERVOLTAGE_THRESHOLD_CODE, OVERVOLTAGE_RESPONSE_SELECT, BRIGHTNESS_MAPPING_SELECT,
            PWM_ACTIVE_LOW, RAMP_SHAPE_LINEAR, PWM_DIMMING_ENABLE}, 11'h0FA);
        chk("sec", {2'b0, TRANSITION_TIME_CODE, DUTY_CHANGE_THRESHOLD}, 11'h02A);
        chk("en", {3'b0, BOOST_AND_SINKS_OFF, BACKLIGHT_MASTER_ENABLE, SINK_ENABLES}, 11'h03F);
        chk("code", BRIGHTNESS_CODE, 11'h7FF);
        u_host_model.wr(8'h05, 16'h0040, 1);
        chk("code", BRIGHTNESS_CODE, 11'h207);
        // hardware enable edge restores defaults
        u_host_model.wr(8'h02, 16'h0000, 1);
        HARDWARE_ENABLE_PIN = 1'b0;
        repeat (6) @(posedge SYS_CLK);
        rdchk(8'h02, 8'hFA);
        HARDWARE_ENABLE_PIN = 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1;
        // one step per microsecond
        n = 0;
        while (UNIT_STEP_TICK !== 1'b1 && n < 200) begin
            @(posedge SYS_CLK) #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge SYS_CLK) #1;
            n++;
        end while (UNIT_STEP_TICK !== 1'b1 && n < 300);
        chk("tick", 11'(n), 11'h07D);
        tally_and_finish();
    end
endmodule : backlight_control_register_bank_tb
bind backlight_control_register_bank backlight_bank_checker u_backlight_bank_checker (.*);
`default_nettype wire
